// ==== rtl/rtcc_defs.svh ====
// Register offsets, field positions, reset values and timing counts of the real-time counter
`ifndef RTCC_DEFS_SVH
`define RTCC_DEFS_SVH
`define RTCC_OFF_COUNT     12'h000
`define RTCC_OFF_CTRL      12'h004
`define RTCC_OFF_MODE      12'h008
`define RTCC_OFF_PRESCALE  12'h00C
`define RTCC_CTRL_PSR_LSB  0
`define RTCC_CTRL_SRC_BIT  5
`define RTCC_CTRL_EDGE_BIT 4
`define RTCC_CTRL_PST_BIT  3
`define RTCC_MODE_TSC_BIT  6
`define RTCC_CTRL_RST      8'h3F
`define RTCC_MODE_RST      8'h00
`define RTCC_COUNT_RST     8'h00
`define RTCC_BASE_NS       10
`define RTCC_SUB_DIV       16'h003D
`endif

// ==== rtl/rtcc_pkg.sv ====
// Types shared by the real-time counter block
`default_nettype none
package rtcc_pkg;
  typedef enum logic [1:0]
  {
    RTCC_CYC2  = 2'b00,
    RTCC_CYC4  = 2'b01,
    RTCC_CYC8  = 2'b10,
    RTCC_CYC16 = 2'b11
  } rtcc_cyc_type;

  typedef enum logic [2:0]
  {
    RTCC_B_IDLE = 3'b001,
    RTCC_B_DATA = 3'b010,
    RTCC_B_RESP = 3'b100
  } rtcc_bst_type;

  typedef struct packed
  {
    logic [7:0] count;
    logic [7:0] ctrl;
    logic [7:0] mode;
    logic [7:0] prescale;
    logic [3:0] cyc_div;
    logic [15:0] sub_div;
    logic       pin_q;
    logic [7:0] rdata;
    logic       rvalid;
    logic       arready;
    logic [1:0] rresp;
    logic       awready;
    logic       wready;
    logic       bvalid;
    logic [1:0] bresp;
    rtcc_bst_type wst;
    logic [11:0] waddr;
    logic       have_aw;
    logic       have_w;
    logic [31:0] wdata;
    logic [3:0] wstrb;
  } rtcc_state_type;
endpackage : rtcc_pkg
`default_nettype wire

// ==== rtl/rtcc_sync.sv ====
// Two-flop synchroniser for the counter input pin
`timescale 1ns/1ps
`default_nettype none
module rtcc_sync
(
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic d,
  output var  logic q
);
  logic meta_r;
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : rtcc_sync
`default_nettype wire

// ==== rtl/rtcc_top.sv ====
// Real-time clock/counter with shared prescaler and AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "rtcc_defs.svh"
module rtcc_top
#(
  parameter rtcc_pkg::rtcc_cyc_type CYCLE_SEL = rtcc_pkg::RTCC_CYC2,
  parameter int                     SUB_DIV   = `RTCC_SUB_DIV
)
(
  input  wire logic        CLK,
  input  wire logic        SRST,
  input  wire logic        REAL_TIME_COUNT_INPUT,
  input  wire logic [11:0] S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output var  logic        S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output var  logic        S_AXI_WREADY,
  output var  logic [1:0]  S_AXI_BRESP,
  output var  logic        S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [11:0] S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output var  logic        S_AXI_ARREADY,
  output var  logic [31:0] S_AXI_RDATA,
  output var  logic [1:0]  S_AXI_RRESP,
  output var  logic        S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output var  logic [7:0]  TIMER_COUNT_REGISTER
);
  // The sub clock divider is 16 bits wide
  if (SUB_DIV < 1 || SUB_DIV > 65535)
  begin : g_bad_sub_div
    $error("SUB_DIV out of range");
  end

  rtcc_pkg::rtcc_state_type s_r;
  rtcc_pkg::rtcc_state_type s_nxt;
  logic pin_s;

  rtcc_sync u_sync
  (
    .clk  (CLK),
    .srst (SRST),
    .d    (REAL_TIME_COUNT_INPUT),
    .q    (pin_s)
  );

  function automatic logic [3:0] cyc_last(input rtcc_pkg::rtcc_cyc_type c);
    case (c)
      rtcc_pkg::RTCC_CYC2:  cyc_last = 4'h1;
      rtcc_pkg::RTCC_CYC4:  cyc_last = 4'h3;
      rtcc_pkg::RTCC_CYC8:  cyc_last = 4'h7;
      default:              cyc_last = 4'hF;
    endcase
  endfunction : cyc_last

  // Prescaler ratio 2^(n+1), n from control bits 2:0
  function automatic logic psr_tick(input logic [7:0] pre, input logic [2:0] n);
    logic [7:0] mask;
    mask = 8'hFF >> (3'd7 - n);
    psr_tick = ((pre & mask) == mask);
  endfunction : psr_tick

  logic base_tick;
  logic cyc_tick;
  logic src_evt;
  logic cnt_evt;
  logic rise;
  logic fall;
  logic w_go;

  // ====================================================================
  // Counting path
  always_comb
  begin
    s_nxt = s_r;
    base_tick = s_r.mode[`RTCC_MODE_TSC_BIT] ? 1'b1 : (s_r.sub_div == 16'(SUB_DIV - 1));
    if (!s_r.mode[`RTCC_MODE_TSC_BIT])
      s_nxt.sub_div = base_tick ? 16'h0000 : s_r.sub_div + 16'h0001;
    cyc_tick = base_tick && (s_r.cyc_div == cyc_last(CYCLE_SEL));
    if (base_tick)
      s_nxt.cyc_div = cyc_tick ? 4'h0 : s_r.cyc_div + 4'h1;
    s_nxt.pin_q = pin_s;
    rise = pin_s && !s_r.pin_q;
    fall = !pin_s && s_r.pin_q;
    if (s_r.ctrl[`RTCC_CTRL_SRC_BIT])
      src_evt = s_r.ctrl[`RTCC_CTRL_EDGE_BIT] ? fall : rise;
    else
      src_evt = cyc_tick;
    // prescaler routed when target bit clear
    cnt_evt = src_evt;
    if (!s_r.ctrl[`RTCC_CTRL_PST_BIT] && src_evt)
    begin
      s_nxt.prescale = s_r.prescale + 8'h01;
      cnt_evt = psr_tick(s_r.prescale, s_r.ctrl[2:0]);
    end
    if (cnt_evt)
      s_nxt.count = s_r.count + 8'h01;

    // ==================================================================
    // AXI4-Lite write
    s_nxt.awready = 1'b0;
    s_nxt.wready  = 1'b0;
    w_go = 1'b0;
    if (s_r.wst == rtcc_pkg::RTCC_B_IDLE)
    begin
      if (S_AXI_AWVALID && !s_r.have_aw && !s_r.awready)
      begin
        s_nxt.awready = 1'b1;
        s_nxt.have_aw = 1'b1;
        s_nxt.waddr   = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !s_r.have_w && !s_r.wready)
      begin
        s_nxt.wready = 1'b1;
        s_nxt.have_w = 1'b1;
        s_nxt.wdata  = S_AXI_WDATA;
        s_nxt.wstrb  = S_AXI_WSTRB;
      end
      if (s_r.have_aw && s_r.have_w)
        s_nxt.wst = rtcc_pkg::RTCC_B_DATA;
    end
    else if (s_r.wst == rtcc_pkg::RTCC_B_DATA)
    begin
      w_go = s_r.wstrb[0];
      s_nxt.bresp = 2'b00;
      if (s_r.waddr == `RTCC_OFF_COUNT)
      begin
        if (w_go)
          s_nxt.count = s_r.wdata[7:0];
        // prescaler cleared only by a count write
        if (w_go)
          s_nxt.prescale = 8'h00;
      end
      else if (s_r.waddr == `RTCC_OFF_CTRL)
      begin
        if (w_go)
          s_nxt.ctrl = s_r.wdata[7:0];
      end
      else if (s_r.waddr == `RTCC_OFF_MODE)
      begin
        if (w_go)
          s_nxt.mode = s_r.wdata[7:0] & 8'h40;
      end
      else if (s_r.waddr != `RTCC_OFF_PRESCALE)
        s_nxt.bresp = 2'b10;
      s_nxt.have_aw = 1'b0;
      s_nxt.have_w  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.wst     = rtcc_pkg::RTCC_B_RESP;
    end
    else
    begin
      if (S_AXI_BREADY)
      begin
        s_nxt.bvalid = 1'b0;
        s_nxt.wst    = rtcc_pkg::RTCC_B_IDLE;
      end
    end

    // ==================================================================
    // AXI4-Lite read
    s_nxt.arready = 1'b0;
    if (s_r.rvalid)
    begin
      if (S_AXI_RREADY)
        s_nxt.rvalid = 1'b0;
    end
    else if (s_r.arready)
      // Address handshake completes at this edge; data may only follow it
      s_nxt.rvalid = 1'b1;
    else if (S_AXI_ARVALID)
    begin
      s_nxt.arready = 1'b1;
      s_nxt.rresp   = 2'b00;
      if (S_AXI_ARADDR == `RTCC_OFF_COUNT)
        s_nxt.rdata = s_r.count;
      else if (S_AXI_ARADDR == `RTCC_OFF_CTRL)
        s_nxt.rdata = s_r.ctrl;
      else if (S_AXI_ARADDR == `RTCC_OFF_MODE)
        s_nxt.rdata = s_r.mode;
      else if (S_AXI_ARADDR == `RTCC_OFF_PRESCALE)
        s_nxt.rdata = s_r.prescale;
      else
      begin
        s_nxt.rdata = 8'h00;
        s_nxt.rresp = 2'b10;
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      s_r          <= '0;
      s_r.ctrl     <= `RTCC_CTRL_RST;
      s_r.mode     <= `RTCC_MODE_RST;
      s_r.count    <= `RTCC_COUNT_RST;
      s_r.wst      <= rtcc_pkg::RTCC_B_IDLE;
    end
    else
      s_r <= s_nxt;
  end

  assign S_AXI_AWREADY        = s_r.awready;
  assign S_AXI_WREADY         = s_r.wready;
  assign S_AXI_BVALID         = s_r.bvalid;
  assign S_AXI_BRESP          = s_r.bresp;
  assign S_AXI_ARREADY        = s_r.arready;
  assign S_AXI_RVALID         = s_r.rvalid;
  assign S_AXI_RRESP          = s_r.rresp;
  assign S_AXI_RDATA          = {24'h00_0000, s_r.rdata};
  assign TIMER_COUNT_REGISTER = s_r.count;

  // ====================================================================
  // Checks
  a_count_load: assert property (@(posedge CLK) disable iff (SRST)
    (s_r.wst == rtcc_pkg::RTCC_B_DATA && s_r.waddr == `RTCC_OFF_COUNT && s_r.wstrb[0])
      |=> (s_r.count == $past(s_r.wdata[7:0])))
    else $error("count not loaded by write");
  a_psr_clear: assert property (@(posedge CLK) disable iff (SRST)
    (s_r.prescale != $past(s_r.prescale) && s_r.prescale != $past(s_r.prescale) + 8'h01)
      |-> (s_r.prescale == 8'h00 && $past(s_r.wst) == rtcc_pkg::RTCC_B_DATA
           && $past(s_r.waddr) == `RTCC_OFF_COUNT))
    else $error("prescaler cleared without count write");
  a_ext_rise: assert property (@(posedge CLK) disable iff (SRST)
    (s_r.ctrl[5] && s_r.ctrl[3] && !s_r.ctrl[4] && pin_s && !s_r.pin_q
     && s_r.wst != rtcc_pkg::RTCC_B_DATA) |=> (s_r.count == $past(s_r.count) + 8'h01))
    else $error("rising edge not counted");
  a_ext_hold: assert property (@(posedge CLK) disable iff (SRST)
    (s_r.ctrl[5] && !(pin_s ^ s_r.pin_q) && s_r.wst != rtcc_pkg::RTCC_B_DATA)
      |=> $stable(s_r.count))
    else $error("count moved without edge");
  a_int_tick: assert property (@(posedge CLK) disable iff (SRST)
    (!s_r.ctrl[5] && s_r.ctrl[3] && cyc_tick && s_r.wst != rtcc_pkg::RTCC_B_DATA)
      |=> (s_r.count == $past(s_r.count) + 8'h01))
    else $error("cycle tick not counted");
  a_psr_route: assert property (@(posedge CLK) disable iff (SRST)
    (s_r.ctrl[3]) |=> (s_r.prescale == $past(s_r.prescale) || s_r.prescale == 8'h00))
    else $error("prescaler ran while assigned elsewhere");
  a_cyc_div: assert property (@(posedge CLK) disable iff (SRST)
    (s_r.cyc_div > cyc_last(CYCLE_SEL)) |-> 1'b0)
    else $error("cycle divider overran");
  a_wrap: assert property (@(posedge CLK) disable iff (SRST)
    (s_r.count == 8'hFF && cnt_evt && s_r.wst != rtcc_pkg::RTCC_B_DATA)
      |=> (s_r.count == 8'h00))
    else $error("counter did not wrap");
  a_main_clk: assert property (@(posedge CLK) disable iff (SRST)
    (s_r.mode[`RTCC_MODE_TSC_BIT] && !cyc_tick)
      |=> (s_r.cyc_div == $past(s_r.cyc_div) + 4'h1))
    else $error("main clock not used as base");
endmodule : rtcc_top
`default_nettype wire

// ==== tb/rtcc_pulse_src.sv ====
// Pulse source that drives the counter input pin
`timescale 1ns/1ps
`default_nettype none
module rtcc_pulse_src
(
  input  wire logic clk,
  output var  logic pin
);
  initial pin = 1'b0;
  task automatic pulse(input int n, input int h);
    repeat (n)
    begin
      @(posedge clk) pin <= 1'b1;
      repeat (h) @(posedge clk);
      pin <= 1'b0;
      repeat (h) @(posedge clk);
    end
    // Sync and edge detect need a few clocks to land
    repeat (5) @(posedge clk);
  endtask : pulse
  task automatic level(input logic v);
    @(posedge clk) pin <= v;
    repeat (8) @(posedge clk);
  endtask : level
endmodule : rtcc_pulse_src
`default_nettype wire

// ==== tb/real_time_clock_counter_bench.sv ====
// Self-checking bench for the real-time counter
`timescale 1ns/1ps
`default_nettype none
`include "rtcc_defs.svh"
`define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin n_mismatch++; \
  $display("ERROR %s exp %h seen %h", nm, e, s); end end
module real_time_clock_counter_bench;
  logic        clk, srst, pin;
  logic [3:0]  wstrb, strb;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, eb;
  logic [7:0]  count;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  logic [33:0] er;
  logic [31:0] seed;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          i;

  rtcc_top #(.SUB_DIV(5)) i_rtcc_top
  (
    .CLK(clk), .SRST(srst), .REAL_TIME_COUNT_INPUT(pin),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .TIMER_COUNT_REGISTER(count)
  );
  rtcc_pulse_src i_rtcc_pulse_src (.clk(clk), .pin(pin));

  // ==========================================
  // Closing report, bus tasks
  task automatic end_sim();
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] e);
    int n;
    @(posedge clk);
    bq.push_back(e);
    awaddr  <= a;
    wdata   <= {24'h00_0000, d};
    wstrb   <= strb;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 100) begin n_mismatch++; end_sim(); end
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] e);
    int n;
    @(posedge clk);
    rq.push_back({e, 24'h00_0000, d});
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (n == 100) begin n_mismatch++; end_sim(); end
  endtask : rd

  // Count delta over a window is phase independent for a periodic tick
  task automatic rate(input int cyc, input logic [7:0] inc);
    logic [7:0] c0;
    @(posedge clk);
    c0 = count;
    repeat (cyc) @(posedge clk);
    `CHK("rate", c0 + inc, count)
  endtask : rate

  always @(posedge clk)
  begin
    if (rvalid && rready && rq.size() > 0)
    begin
      er = rq.pop_front();
      `CHK("read", er, {rresp, rdata})
    end
    if (bvalid && bready && bq.size() > 0)
    begin
      eb = bq.pop_front();
      `CHK("bresp", eb, bresp)
    end
  end

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    srst    = 1'b1;
    awvalid = 1'b0;
    wvalid  = 1'b0;
    bready  = 1'b0;
    arvalid = 1'b0;
    rready  = 1'b0;
    awaddr  = 12'h000;
    araddr  = 12'h000;
    wdata   = 32'h0000_0000;
    wstrb   = 4'hF;
    strb    = 4'hF;
    seed    = 32'h0000_9212;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    rd(`RTCC_OFF_COUNT, `RTCC_COUNT_RST, 2'b00);
    rd(`RTCC_OFF_CTRL, `RTCC_CTRL_RST, 2'b00);
    rd(`RTCC_OFF_MODE, `RTCC_MODE_RST, 2'b00);
    rd(12'h010, 8'h00, 2'b10);
    wr(12'h010, 8'h55, 2'b10);
    for (i = 0; i < 4; i++)
    begin
      seed = xs(seed);
      wr(`RTCC_OFF_COUNT, seed[7:0], 2'b00);
      rd(`RTCC_OFF_COUNT, seed[7:0], 2'b00);
    end
    wr(`RTCC_OFF_CTRL, 8'h28, 2'b00);
    wr(`RTCC_OFF_COUNT, 8'hFE, 2'b00);
    i_rtcc_pulse_src.pulse(3, 2);
    rd(`RTCC_OFF_COUNT, 8'h01, 2'b00);
    wr(`RTCC_OFF_CTRL, 8'h38, 2'b00);
    wr(`RTCC_OFF_COUNT, 8'h10, 2'b00);
    i_rtcc_pulse_src.level(1'b1);
    rd(`RTCC_OFF_COUNT, 8'h10, 2'b00);
    i_rtcc_pulse_src.level(1'b0);
    rd(`RTCC_OFF_COUNT, 8'h11, 2'b00);
    wr(`RTCC_OFF_CTRL, 8'h20, 2'b00);
    wr(`RTCC_OFF_COUNT, 8'h00, 2'b00);
    i_rtcc_pulse_src.pulse(3, 5);
    rd(`RTCC_OFF_COUNT, 8'h01, 2'b00);
    wr(`RTCC_OFF_COUNT, 8'h40, 2'b00);
    rd(`RTCC_OFF_PRESCALE, 8'h00, 2'b00);
    i_rtcc_pulse_src.pulse(1, 2);
    rd(`RTCC_OFF_COUNT, 8'h40, 2'b00);
    i_rtcc_pulse_src.pulse(1, 2);
    rd(`RTCC_OFF_COUNT, 8'h41, 2'b00);
    // A write with its byte strobe off must leave count and prescaler alone
    strb = 4'h0;
    wr(`RTCC_OFF_COUNT, 8'h99, 2'b00);
    strb = 4'hF;
    rd(`RTCC_OFF_COUNT, 8'h41, 2'b00);
    wr(`RTCC_OFF_CTRL, 8'h08, 2'b00);
    rd(`RTCC_OFF_PRESCALE, 8'h02, 2'b00);
    wr(`RTCC_OFF_MODE, 8'h40, 2'b00);
    rate(20, 8'h0A);
    wr(`RTCC_OFF_MODE, 8'h00, 2'b00);
    rate(100, 8'h0A);
    end_sim();
  end
endmodule : real_time_clock_counter_bench
`default_nettype wire
